// ===== verilog/qwsc_cfg.svh
// constants of the quad wiper serial control block
// assumes inclusion by bare name from the package and the design
`ifndef QWSC_CFG_SVH
`define QWSC_CFG_SVH

// ----------------------------------------
// wiper codes and channel count
// ----------------------------------------
`define QW_MIDSCALE     8'h80
`define QW_CHANNELS     4

// ----------------------------------------
// shift-port word layout
// ----------------------------------------
`define QW_SPI_BITS     10
`define QW_SPI_SEL_HI   9
`define QW_SPI_SEL_LO   8
`define QW_SPI_DATA_HI  7

// ----------------------------------------
// bus address and instruction byte layout
// ----------------------------------------
`define QW_ADDR_PREFIX  5'h0b
`define QW_INS_SEL_HI   6
`define QW_INS_SEL_LO   5
`define QW_INS_RS       4
`define QW_INS_SD       3
`define QW_INS_AUX_ONE  2
`define QW_INS_AUX_TWO  1

// ----------------------------------------
// bit counter marks
// ----------------------------------------
`define QW_BIT_ACK      4'h8
`define QW_BIT_END      4'h9

`endif

// ===== verilog/qwsc_pkg.sv
// types of the quad wiper serial control block
// assumes qwsc_cfg.svh on the include path
`default_nettype none
`include "qwsc_cfg.svh"

package qwsc_pkg;

   // ----------------------------------------
   // two-wire slave phases
   // ----------------------------------------
   typedef enum logic [2:0] {
      I2C_IDLE,
      I2C_ADDR,
      I2C_INSTR,
      I2C_WDATA,
      I2C_RDATA
   } i2c_state_t;

   // ----------------------------------------
   // system clock state
   // ----------------------------------------
   typedef struct packed {
      logic                              choice_s1;
      logic                              choice_s2;
      logic                              shutdown_pin_s1;
      logic                              shutdown_pin_s2;
      logic                              clr_s1;
      logic                              clr_s2;
      logic                              adlo_s1;
      logic                              adlo_s2;
      logic                              adhi_s1;
      logic                              adhi_s2;
      logic                              cs_s1;
      logic                              cs_s2;
      logic                              cs_s3;
      logic                              scl_s1;
      logic                              scl_s2;
      logic                              scl_s3;
      logic                              sda_s1;
      logic                              sda_s2;
      logic                              sda_s3;
      logic [`QW_CHANNELS-1:0][7:0]      wiper;
      logic [`QW_CHANNELS-1:0]           shutdown_pin_bit;
      logic [`QW_CHANNELS-1:0]           shutdown_pin_out;
      logic                              aux_one;
      logic                              aux_two;
      logic [1:0]                        sel;
      i2c_state_t                        state;
      logic [3:0]                        bitcnt;
      logic [7:0]                        rx;
      logic [7:0]                        tx;
      logic                              rw;
      logic                              nack;
      logic                              sda_oe;
   } sys_state_t;

   // ----------------------------------------
   // link clock state
   // ----------------------------------------
   typedef struct packed {
      logic [`QW_SPI_BITS-1:0]           shift;
   } link_state_t;

   typedef struct packed {
      logic                              sdo;
   } link_fall_t;

endpackage

`default_nettype wire

// ===== verilog/quad_wiper_serial_control.sv
// control logic of a four-channel wiper device with shift port and two-wire slave
// assumes shift clock on its own domain, two-wire pins slow against CLK_SYS
//
// Notes on behaviour
// R01 - interface choice pin low selects shift port, high selects two-wire slave
// R02 - master sends 10 bits msb first: two select bits then eight data
// R03 - while chip select low, each rising shift clock shifts in the input bit
// R04 - chip select rising loads last 10 bits into the addressed wiper latch
// R05 - select 00,01,10,11 address channels one to four
// R06 - shutdown pin asserted forces the serial output released high
// R07 - hardware clear holds latches at midscale while low; after release they stay midscale until a write
// R08 - serial output changes on falling shift clock for downstream rising sample
// R09 - two chained devices take 20 bits, far device first, then chip select
// R10 - slave address is 01011 plus two address pins, then read/write bit
// R11 - matching address is acknowledged by pulling data low on ninth clock
// R12 - start is data falling with clock high; stop is data rising
// R13 - instruction byte: ignore, select pair, midscale, shutdown, two aux, ignore
// R14 - midscale bit overwrites the selected latch with midscale until its next data write
// R15 - shutdown bit shuts the selected channel only, latch kept intact
// R16 - shutdown pin shuts all channels; shutdown bit only the addressed one
// R17 - two aux outputs follow the aux bits of every instruction byte
// R18 - after instruction, data byte is acknowledged and loaded into the latch
// R19 - data line changes only while clock low, stable while clock high
// R20 - read returns the last selected channel right after the address ack
// R21 - reading master leaves no acknowledge after data, then issues stop
// R22 - further data bytes keep updating until stop; repeated reads supplied
// R23 - a channel shut by its bit leaves shutdown only by an instruction clearing that bit; one shut by the pin leaves it when the pin is released
// R24 - aux outputs are low from reset until an instruction changes them
// R25 - midscale is code 80 hex, loaded into all latches at reset
`timescale 1ns/100ps
`default_nettype none
`include "qwsc_cfg.svh"

module quad_wiper_serial_control (
   input  wire logic                      CLK_SYS,
   input  wire logic                      RST_B,
   input  wire logic                      SPI_SCLK,
   input  wire logic                      SPI_CS_B,
   input  wire logic                      SPI_SDI,
   output logic                           SPI_SDO_O,
   output logic                           SPI_SDO_OE,
   input  wire logic                      SCL_IN,
   input  wire logic                      SDA_IN,
   output logic                           SDA_O,
   output logic                           SDA_OE,
   input  wire logic                      INTERFACE_CHOICE_PIN,
   input  wire logic                      SHUTDOWN_PIN_B,
   input  wire logic                      HARDWARE_CLEAR_PIN_B,
   input  wire logic                      BUS_ADDRESS_PIN_LO,
   input  wire logic                      BUS_ADDRESS_PIN_HI,
   output logic [7:0]                     WIPER_ONE,
   output logic [7:0]                     WIPER_TWO,
   output logic [7:0]                     WIPER_THREE,
   output logic [7:0]                     WIPER_FOUR,
   output logic [`QW_CHANNELS-1:0]        SHUTDOWN_ACTIVE,
   output logic                           AUX_OUTPUT_ONE,
   output logic                           AUX_OUTPUT_TWO
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   localparam qwsc_pkg::sys_state_t SYS_RESET = '{
      wiper    : {`QW_CHANNELS{`QW_MIDSCALE}},
      state    : qwsc_pkg::I2C_IDLE,
      choice_s1: 1'b0, choice_s2: 1'b0,
      shutdown_pin_s1  : 1'b1, shutdown_pin_s2  : 1'b1,
      clr_s1   : 1'b1, clr_s2   : 1'b1,
      cs_s1    : 1'b1, cs_s2    : 1'b1, cs_s3: 1'b1,
      scl_s1   : 1'b1, scl_s2   : 1'b1, scl_s3: 1'b1,
      sda_s1   : 1'b1, sda_s2   : 1'b1, sda_s3: 1'b1,
      default  : '0
   };

   qwsc_pkg::sys_state_t                  r;
   qwsc_pkg::sys_state_t                  next_r;
   qwsc_pkg::link_state_t                 l;
   qwsc_pkg::link_state_t                 next_l;
   qwsc_pkg::link_fall_t                  f;
   qwsc_pkg::link_fall_t                  next_f;

   logic                                  start_seen;
   logic                                  stop_seen;
   logic                                  scl_rise;
   logic                                  scl_fall;
   logic                                  addr_match;
   logic                                  cs_rise;

   // ----------------------------------------
   // link domain: shift register
   // ----------------------------------------
   always_comb begin
      next_l = l;
      if (!SPI_CS_B) begin
         next_l.shift = {l.shift[`QW_SPI_BITS-2:0], SPI_SDI}; // R03 R02 R09
      end
   end

   always_ff @(posedge SPI_SCLK or negedge RST_B) begin
      if (!RST_B) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // ----------------------------------------
   // link domain: serial output on falling edge
   // ----------------------------------------
   always_comb begin
      next_f.sdo = l.shift[`QW_SPI_BITS-1]; // R08
   end

   always_ff @(negedge SPI_SCLK or negedge RST_B) begin
      if (!RST_B) begin
         f <= '{sdo: 1'b1};
      end else begin
         f <= next_f;
      end
   end

   assign SPI_SDO_O  = 1'b0;
   assign SPI_SDO_OE = ~f.sdo & SHUTDOWN_PIN_B; // R06

   // ----------------------------------------
   // system domain: edge and condition detect
   // ----------------------------------------
   assign scl_rise   = r.scl_s2 & ~r.scl_s3;
   assign scl_fall   = ~r.scl_s2 & r.scl_s3;
   assign start_seen = r.scl_s2 & r.scl_s3 & r.sda_s3 & ~r.sda_s2; // R12
   assign stop_seen  = r.scl_s2 & r.scl_s3 & ~r.sda_s3 & r.sda_s2; // R12
   assign cs_rise    = r.cs_s2 & ~r.cs_s3;
   assign addr_match = (r.rx[7:1] == {`QW_ADDR_PREFIX, r.adhi_s2, r.adlo_s2}); // R10

   // ----------------------------------------
   // system domain: next state
   // ----------------------------------------
   always_comb begin
      next_r           = r;
      next_r.choice_s1 = INTERFACE_CHOICE_PIN;
      next_r.choice_s2 = r.choice_s1;
      next_r.shutdown_pin_s1   = SHUTDOWN_PIN_B;
      next_r.shutdown_pin_s2   = r.shutdown_pin_s1;
      next_r.clr_s1    = HARDWARE_CLEAR_PIN_B;
      next_r.clr_s2    = r.clr_s1;
      next_r.adlo_s1   = BUS_ADDRESS_PIN_LO;
      next_r.adlo_s2   = r.adlo_s1;
      next_r.adhi_s1   = BUS_ADDRESS_PIN_HI;
      next_r.adhi_s2   = r.adhi_s1;
      next_r.cs_s1     = SPI_CS_B;
      next_r.cs_s2     = r.cs_s1;
      next_r.cs_s3     = r.cs_s2;
      next_r.scl_s1    = SCL_IN;
      next_r.scl_s2    = r.scl_s1;
      next_r.scl_s3    = r.scl_s2;
      next_r.sda_s1    = SDA_IN;
      next_r.sda_s2    = r.sda_s1;
      next_r.sda_s3    = r.sda_s2;
      next_r.shutdown_pin_out  = r.shutdown_pin_bit | {`QW_CHANNELS{~r.shutdown_pin_s2}}; // R16 R15

      // shift-port load, shift register stable while chip select high
      if (!r.choice_s2 && cs_rise) begin // R01 R04
         next_r.wiper[l.shift[`QW_SPI_SEL_HI:`QW_SPI_SEL_LO]] =
            l.shift[`QW_SPI_DATA_HI:0]; // R05
      end

      if (!r.choice_s2) begin // R01
         next_r.state  = qwsc_pkg::I2C_IDLE;
         next_r.sda_oe = 1'b0;
      end else if (start_seen) begin
         next_r.state  = qwsc_pkg::I2C_ADDR;
         next_r.bitcnt = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop_seen) begin
         next_r.state  = qwsc_pkg::I2C_IDLE; // R22
         next_r.sda_oe = 1'b0;
      end else if (scl_rise) begin
         case (r.state)
            qwsc_pkg::I2C_IDLE: begin
            end
            qwsc_pkg::I2C_RDATA: begin
               if (r.bitcnt < `QW_BIT_ACK) begin
                  next_r.bitcnt = r.bitcnt + 4'h1;
               end else if (r.bitcnt == `QW_BIT_ACK) begin
                  next_r.nack   = r.sda_s2; // R21
                  next_r.bitcnt = `QW_BIT_END;
               end
            end
            default: begin
               if (r.bitcnt < `QW_BIT_ACK) begin
                  next_r.rx     = {r.rx[6:0], r.sda_s2}; // R19
                  next_r.bitcnt = r.bitcnt + 4'h1;
               end else if (r.bitcnt == `QW_BIT_ACK) begin
                  next_r.bitcnt = `QW_BIT_END;
               end
            end
         endcase
      end else if (scl_fall) begin
         case (r.state)
            qwsc_pkg::I2C_ADDR: begin
               if (r.bitcnt == `QW_BIT_ACK) begin
                  if (addr_match) begin
                     next_r.sda_oe = 1'b1; // R11
                     next_r.rw     = r.rx[0];
                  end else begin
                     next_r.state  = qwsc_pkg::I2C_IDLE; // R11
                  end
               end else if (r.bitcnt == `QW_BIT_END) begin
                  next_r.bitcnt = 4'h0;
                  if (r.rw) begin
                     next_r.state  = qwsc_pkg::I2C_RDATA; // R20
                     next_r.tx     = r.wiper[r.sel];
                     next_r.sda_oe = ~r.wiper[r.sel][7]; // R19
                  end else begin
                     next_r.state  = qwsc_pkg::I2C_INSTR;
                     next_r.sda_oe = 1'b0;
                  end
               end
            end
            qwsc_pkg::I2C_INSTR: begin
               if (r.bitcnt == `QW_BIT_ACK) begin
                  next_r.sda_oe = 1'b1;
                  next_r.sel    = r.rx[`QW_INS_SEL_HI:`QW_INS_SEL_LO]; // R13 R05
                  if (r.rx[`QW_INS_RS]) begin
                     next_r.wiper[r.rx[`QW_INS_SEL_HI:`QW_INS_SEL_LO]] =
                        `QW_MIDSCALE; // R14
                  end
                  next_r.shutdown_pin_bit[r.rx[`QW_INS_SEL_HI:`QW_INS_SEL_LO]] =
                     r.rx[`QW_INS_SD]; // R15 R23
                  next_r.aux_one = r.rx[`QW_INS_AUX_ONE]; // R17
                  next_r.aux_two = r.rx[`QW_INS_AUX_TWO]; // R17
               end else if (r.bitcnt == `QW_BIT_END) begin
                  next_r.sda_oe = 1'b0;
                  next_r.bitcnt = 4'h0;
                  next_r.state  = qwsc_pkg::I2C_WDATA;
               end
            end
            qwsc_pkg::I2C_WDATA: begin
               if (r.bitcnt == `QW_BIT_ACK) begin
                  next_r.sda_oe         = 1'b1; // R18
                  next_r.wiper[r.sel]   = r.rx; // R18 R22
               end else if (r.bitcnt == `QW_BIT_END) begin
                  next_r.sda_oe = 1'b0;
                  next_r.bitcnt = 4'h0;
               end
            end
            qwsc_pkg::I2C_RDATA: begin
               if (r.bitcnt != 4'h0 && r.bitcnt < `QW_BIT_ACK) begin
                  next_r.tx     = {r.tx[6:0], 1'b0};
                  next_r.sda_oe = ~r.tx[6]; // R19
               end else if (r.bitcnt == `QW_BIT_ACK) begin
                  next_r.sda_oe = 1'b0;
               end else if (r.bitcnt == `QW_BIT_END) begin
                  if (r.nack) begin
                     next_r.state  = qwsc_pkg::I2C_IDLE; // R21
                     next_r.sda_oe = 1'b0;
                  end else begin
                     next_r.bitcnt = 4'h0;
                     next_r.tx     = r.wiper[r.sel]; // R22
                     next_r.sda_oe = ~r.wiper[r.sel][7];
                  end
               end
            end
            default: begin
               next_r.sda_oe = 1'b0;
            end
         endcase
      end

      // hardware clear holds every latch at midscale
      if (!r.clr_s2) begin
         for (int i = 0; i < `QW_CHANNELS; i++) begin
            next_r.wiper[i] = `QW_MIDSCALE; // R07
         end
      end
   end

   // ----------------------------------------
   // system domain: registers
   // ----------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         r <= SYS_RESET; // R25 R24
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign SDA_O           = 1'b0;
   assign SDA_OE          = r.sda_oe;
   assign WIPER_ONE       = r.wiper[0];
   assign WIPER_TWO       = r.wiper[1];
   assign WIPER_THREE     = r.wiper[2];
   assign WIPER_FOUR      = r.wiper[3];
   assign SHUTDOWN_ACTIVE = r.shutdown_pin_out;
   assign AUX_OUTPUT_ONE  = r.aux_one;
   assign AUX_OUTPUT_TWO  = r.aux_two;

endmodule

`default_nettype wire

// ===== testbench/qwsc_asserts.sv
// port checker of the quad wiper serial control block
// assumes binding onto quad_wiper_serial_control, one system clock
`timescale 1ns/100ps
`default_nettype none

module qwsc_asserts (
   input wire logic       CLK_SYS,
   input wire logic       RST_B,
   input wire logic       SPI_SCLK,
   input wire logic       SPI_CS_B,
   input wire logic       SPI_SDO_OE,
   input wire logic       SCL_IN,
   input wire logic       SDA_OE,
   input wire logic       INTERFACE_CHOICE_PIN,
   input wire logic       SHUTDOWN_PIN_B,
   input wire logic       HARDWARE_CLEAR_PIN_B,
   input wire logic [7:0] WIPER_ONE,
   input wire logic [7:0] WIPER_TWO,
   input wire logic [7:0] WIPER_THREE,
   input wire logic [7:0] WIPER_FOUR,
   input wire logic [3:0] SHUTDOWN_ACTIVE,
   input wire logic       AUX_OUTPUT_ONE,
   input wire logic       AUX_OUTPUT_TWO
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   wire logic mid = WIPER_ONE == 8'h80 && WIPER_TWO == 8'h80
                    && WIPER_THREE == 8'h80 && WIPER_FOUR == 8'h80;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   a_sdo_release: assert property (!SHUTDOWN_PIN_B |-> !SPI_SDO_OE)
      else $error("serial output pulled during shutdown");
   a_sdo_on_fall: assert property ($changed(SPI_SDO_OE) && $stable(SHUTDOWN_PIN_B)
      |-> !SPI_SCLK)
      else $error("serial output moved outside clock low phase");
   a_clear_mid: assert property (!HARDWARE_CLEAR_PIN_B [*4] |-> mid)
      else $error("clear did not give midscale");
   a_pin_all: assert property (!SHUTDOWN_PIN_B [*5] |-> SHUTDOWN_ACTIVE == 4'hf)
      else $error("shutdown pin missed a channel");
   a_slave_quiet: assert property (!INTERFACE_CHOICE_PIN [*4] |-> !SDA_OE)
      else $error("data line pulled in shift mode");
   a_sda_low_phase: assert property ($changed(SDA_OE) |-> !SCL_IN)
      else $error("data line moved with clock high");
   a_wiper_hold: assert property ((!SPI_CS_B && !INTERFACE_CHOICE_PIN
      && HARDWARE_CLEAR_PIN_B) [*6] |-> $stable(WIPER_ONE) && $stable(WIPER_TWO)
      && $stable(WIPER_THREE) && $stable(WIPER_FOUR))
      else $error("wiper moved while select low");
   a_reset_vals: assert property (!$past(RST_B) |-> !AUX_OUTPUT_ONE && !AUX_OUTPUT_TWO
      && mid)
      else $error("bad values after reset");

   cover property (SDA_OE [*3]);
   cover property ($rose(SPI_CS_B));
   cover property (SHUTDOWN_ACTIVE == 4'hf);
endmodule

bind quad_wiper_serial_control qwsc_asserts qwsc_asserts_inst (
   .CLK_SYS(CLK_SYS), .RST_B(RST_B), .SPI_SCLK(SPI_SCLK), .SPI_CS_B(SPI_CS_B),
   .SPI_SDO_OE(SPI_SDO_OE), .SCL_IN(SCL_IN), .SDA_OE(SDA_OE),
   .INTERFACE_CHOICE_PIN(INTERFACE_CHOICE_PIN), .SHUTDOWN_PIN_B(SHUTDOWN_PIN_B),
   .HARDWARE_CLEAR_PIN_B(HARDWARE_CLEAR_PIN_B), .WIPER_ONE(WIPER_ONE),
   .WIPER_TWO(WIPER_TWO), .WIPER_THREE(WIPER_THREE), .WIPER_FOUR(WIPER_FOUR),
   .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE), .AUX_OUTPUT_ONE(AUX_OUTPUT_ONE),
   .AUX_OUTPUT_TWO(AUX_OUTPUT_TWO));

`default_nettype wire

// ===== testbench/serial_master_model.sv
// bus master model: shift port frames and two-wire transfers
// assumes pull-ups on both data wires, resolved by the bench
`timescale 1ns/100ps
`default_nettype none

module serial_master_model (
   output logic      sclk,
   output logic      cs_b,
   output logic      sdi,
   input  wire logic sdo,
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      sdi = 1'b0;
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // ----------------------------------------
   // shift port, clock still between frames
   // ----------------------------------------
   task automatic spi_frame(input logic [19:0] w, input int n, output logic [19:0] back);
      back = '0;
      cs_b = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi = w[i];
         #24 sclk = 1'b1;
         back = {back[18:0], sdo};
         #24 sclk = 1'b0;
      end
      sdi = ~sdi;
      #24 cs_b = 1'b1;
      #200;
   endtask

   // ----------------------------------------
   // two-wire master, 400 ns phases
   // ----------------------------------------
   task automatic i2c_start();
      sda_pull = 1'b1;
      #400 scl = 1'b0;
   endtask

   task automatic i2c_stop();
      #100 sda_pull = 1'b1;
      #300 scl = 1'b1;
      #200 sda_pull = 1'b0;
      #400;
   endtask

   task automatic i2c_byte(input logic [7:0] b, input logic rel9, output logic [7:0] r,
                           output logic ack);
      logic [8:0] v;
      logic [8:0] s;
      v = {b, rel9};
      s = '0;
      for (int i = 8; i >= 0; i--) begin
         #100 sda_pull = ~v[i];
         #300 scl = 1'b1;
         #200 s = {s[7:0], sda};
         #200 scl = 1'b0;
      end
      r = s[8:1];
      ack = ~s[0];
   endtask
endmodule

`default_nettype wire

// ===== testbench/quad_wiper_serial_control_tb.sv
// self-checking bench of the quad wiper serial control block
// assumes the master model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "qwsc_cfg.svh"

module quad_wiper_serial_control_tb;
   logic            clk, rst_b, choice, shutdown_pin_b, clr_b, ad_lo, ad_hi;
   wire logic       sclk, cs_b, sdi, sdo_oe, sdo_o, scl, sda_pull, sda_oe, sda_o;
   wire logic       aux1, aux2, sdo_w, sda_w;
   wire logic [7:0] wp [4];
   wire logic [3:0] sd_act;
   logic [19:0]     back;
   logic [7:0]      r;
   logic            ack;
   int              failures, tests_run;

   assign sdo_w = sdo_oe ? sdo_o : 1'b1;
   assign sda_w = ~sda_pull & (sda_oe ? sda_o : 1'b1);

   quad_wiper_serial_control quad_wiper_serial_control_inst (
      .CLK_SYS(clk), .RST_B(rst_b), .SPI_SCLK(sclk), .SPI_CS_B(cs_b), .SPI_SDI(sdi),
      .SPI_SDO_O(sdo_o), .SPI_SDO_OE(sdo_oe), .SCL_IN(scl), .SDA_IN(sda_w),
      .SDA_O(sda_o), .SDA_OE(sda_oe), .INTERFACE_CHOICE_PIN(choice),
      .SHUTDOWN_PIN_B(shutdown_pin_b), .HARDWARE_CLEAR_PIN_B(clr_b), .BUS_ADDRESS_PIN_LO(ad_lo),
      .BUS_ADDRESS_PIN_HI(ad_hi), .WIPER_ONE(wp[0]), .WIPER_TWO(wp[1]),
      .WIPER_THREE(wp[2]), .WIPER_FOUR(wp[3]), .SHUTDOWN_ACTIVE(sd_act),
      .AUX_OUTPUT_ONE(aux1), .AUX_OUTPUT_TWO(aux2));

   serial_master_model serial_master_model_inst (
      .sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo_w), .scl(scl),
      .sda_pull(sda_pull), .sda(sda_w));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] ins, input logic [7:0] d, input int nd);
      serial_master_model_inst.i2c_start();
      serial_master_model_inst.i2c_byte({`QW_ADDR_PREFIX, ad_hi, ad_lo, 1'b0}, 1'b1, r, ack);
      chk({7'h0, ack}, 8'h01);
      serial_master_model_inst.i2c_byte(ins, 1'b1, r, ack);
      chk({7'h0, ack}, 8'h01);
      for (int k = 0; k < nd; k++) begin
         serial_master_model_inst.i2c_byte(8'(d + k), 1'b1, r, ack);
         chk({7'h0, ack}, 8'h01);
      end
      serial_master_model_inst.i2c_stop();
   endtask

   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      #400000;
      failures++;
      end_of_test();
   end

   initial begin
      rst_b = 1'b0;
      choice = 1'b0;
      shutdown_pin_b = 1'b1;
      clr_b = 1'b1;
      ad_lo = 1'b0;
      ad_hi = 1'b1;
      tick(8);
      rst_b = 1'b1;
      tick(3);
      for (int c = 0; c < 4; c++) chk(wp[c], `QW_MIDSCALE);
      chk({6'h0, aux1, aux2}, 8'h00);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         serial_master_model_inst.spi_frame(20'({c[1:0], 8'(c * 8'h35 + 8'h1e)}), 10, back);
         chk(wp[c], 8'(c * 8'h35 + 8'h1e));
      end
      serial_master_model_inst.spi_frame({2'b11, 8'h5c, 2'b01, 8'ha7}, 20, back);
      chk(wp[1], 8'ha7);
      chk(back[7:0], 8'h5c);
      chk(back[17:10], 8'hbd);
      chk(wp[3], 8'hbd);
      $display("test shift port done");
      clr_b = 1'b0;
      tick(6);
      for (int c = 0; c < 4; c++) chk(wp[c], 8'h80);
      clr_b = 1'b1;
      tick(6);
      chk(wp[1], 8'h80);
      shutdown_pin_b = 1'b0;
      tick(8);
      chk({4'h0, sd_act}, 8'h0f);
      serial_master_model_inst.spi_frame(20'h1ab, 10, back);
      chk(back[7:0], 8'hff);
      shutdown_pin_b = 1'b1;
      tick(8);
      chk({4'h0, sd_act}, 8'h00);
      chk(wp[1], 8'hab);
      $display("test pins done");
      choice = 1'b1;
      tick(4);
      wr(8'h44, 8'h5a, 2);
      chk(wp[2], 8'h5b);
      chk({6'h0, aux1, aux2}, 8'h02);
      serial_master_model_inst.i2c_start();
      serial_master_model_inst.i2c_byte({`QW_ADDR_PREFIX, ad_hi, ad_lo, 1'b1}, 1'b1, r, ack);
      chk({7'h0, ack}, 8'h01);
      serial_master_model_inst.i2c_byte(8'hff, 1'b0, r, ack);
      chk(r, 8'h5b);
      serial_master_model_inst.i2c_byte(8'hff, 1'b1, r, ack);
      chk(r, 8'h5b);
      serial_master_model_inst.i2c_stop();
      serial_master_model_inst.i2c_start();
      serial_master_model_inst.i2c_byte({`QW_ADDR_PREFIX, ~ad_hi, ad_lo, 1'b0}, 1'b1, r, ack);
      chk({7'h0, ack}, 8'h00);
      serial_master_model_inst.i2c_stop();
      $display("test two-wire transfers done");
      wr(8'h28, 8'h00, 0);
      chk({4'h0, sd_act}, 8'h02);
      wr(8'h06, 8'h00, 0);
      chk({4'h0, sd_act}, 8'h02);
      chk({6'h0, aux1, aux2}, 8'h03);
      wr(8'h20, 8'h00, 0);
      chk({4'h0, sd_act}, 8'h00);
      chk(wp[1], 8'hab);
      wr(8'h50, 8'h00, 0);
      chk(wp[2], 8'h80);
      wr(8'h40, 8'h00, 0);
      chk(wp[2], 8'h80);
      serial_master_model_inst.spi_frame(20'h077, 10, back);
      chk(wp[0], 8'h80);
      $display("test instructions done");
      end_of_test();
   end
endmodule

`default_nettype wire
